/* core/pmt8_defs.svh */
// Purpose: constants for the eight-bit period match timer
// Assumes: AHB-Lite register window, word aligned, byte addresses below
// Notes:   timer clocked from the instruction-clock enable (one per four mclk)
// What this block does
// (R01) timer counts only instruction-clock ticks, one per four system clocks
// (R02) counter and period registers are both eight bits wide
// (R03) prescaler divides input clock by one, four or sixteen
// (R04) each prescaler output adds one to the counter
// (R05) counter compared continuously with period, counts up from zero
// (R06) after a match the counter loads zero on the next increment
// (R07) each match advances the postscaler count by one
// (R08) postscaler divides matches by one to sixteen
// (R09) each postscaler output sets the match interrupt flag
// (R10) software reads and writes counter and period any time
// (R11) reset clears counter to zero and sets period to all ones
// (R12) timer runs while run enable is one, stops while zero
// (R13) control register fields select prescale and postscale ratios
// (R14) prescaler and postscaler counts clear on counter or control write, reset
// (R15) control register write leaves the counter unchanged
// (R16) while stopped, counts hold and no scaler output or flag occurs
`ifndef PMT8_DEFS_SVH
`define PMT8_DEFS_SVH
`define PMT8_ADDR_COUNT     12'h000
`define PMT8_ADDR_PERIOD    12'h004
`define PMT8_ADDR_CONTROL   12'h008
`define PMT8_ADDR_FLAGS     12'h00c
`define PMT8_COUNT_RESET    8'h00
`define PMT8_PERIOD_RESET   8'hff
`define PMT8_CTRL_RESET     7'h00
`define PMT8_CKPS_LSB       0
`define PMT8_RUN_BIT        2
`define PMT8_OUTPS_LSB      3
`define PMT8_FLAG_BIT       1
`define PMT8_ICLK_DIV       2'h3
`define PMT8_PRE_DIV1       4'h0
`define PMT8_PRE_DIV4       4'h3
`define PMT8_PRE_DIV16      4'hf
`endif

/* core/pmt8_pkg.sv */
// Purpose: types for the eight-bit period match timer
// Assumes: nothing
// Notes:   ahb state of the register slave
package pmt8_pkg;
    typedef enum logic [1:0] {
        PMT8_PHASE_IDLE,
        PMT8_PHASE_WRITE,
        PMT8_PHASE_READ
    } pmt8_phase_e;
endpackage

/* core/pmt8_scaler.sv */
// Purpose: prescaler and postscaler pair of the period timer
// Assumes: tick_in is a one-cycle pulse on mclk
// Notes:   clear wins over counting
`timescale 1ns/100ps
`include "pmt8_defs.svh"
module pmt8_scaler
    import pmt8_pkg::*;
(
    input  wire logic       mclk,      // system clock
    input  wire logic       reset,     // synchronous, active high
    input  wire logic       clear,     // clears both counts
    input  wire logic       tick_in,   // instruction tick while running
    input  wire logic [1:0] pre_sel,   // prescale select
    input  wire logic       match_in,  // counter equals period, not qualified by tick
    input  wire logic [3:0] post_sel,  // postscale select
    output logic            pre_pulse, // prescaler output
    output logic            post_pulse // postscaler output
);
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic [3:0] post_q;
    logic [3:0] post_d;
    logic [3:0] pre_top;

    always_comb begin
        case (pre_sel)
            2'h0:    pre_top = `PMT8_PRE_DIV1;
            2'h1:    pre_top = `PMT8_PRE_DIV4;
            default: pre_top = `PMT8_PRE_DIV16;
        endcase
    end

    assign pre_pulse  = tick_in && (pre_q == pre_top);          // [R03]
    assign post_pulse = pre_pulse && match_in && (post_q == post_sel); // [R08]

    always_comb begin
        pre_d  = pre_q;
        post_d = post_q;
        if (clear) begin
            pre_d  = 4'h0;                                      // [R14]
            post_d = 4'h0;
        end else begin
            if (tick_in)
                pre_d = pre_pulse ? 4'h0 : pre_q + 4'h1;
            if (pre_pulse && match_in)
                post_d = post_pulse ? 4'h0 : post_q + 4'h1;     // [R07]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pre_q  <= 4'h0;
            post_q <= 4'h0;
        end else begin
            pre_q  <= pre_d;
            post_q <= post_d;
        end
    end
endmodule

/* core/pmt8_timer.sv */
// Purpose: eight-bit period match timer with AHB-Lite register slave
// Assumes: one master, single word transfers, mclk at 100 MHz
// Notes:   flag is set-wins over a software clear in the same cycle
`timescale 1ns/100ps
`include "pmt8_defs.svh"
module pmt8_timer
    import pmt8_pkg::*;
(
    input  wire logic        mclk,        // system clock
    input  wire logic        reset,       // synchronous, active high
    input  wire logic        hsel,        // slave select
    input  wire logic [11:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready
    output logic [31:0]      hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp,       // always okay
    output logic             match_interrupt_flag, // flag level
    output logic [7:0]       timer_count_out       // counter value
);
    logic [1:0]  iclk_q;
    logic [1:0]  iclk_d;
    logic [7:0]  count_q;                                    // [R02]
    logic [7:0]  count_d;
    logic [7:0]  period_q;                                   // [R02]
    logic [7:0]  period_d;
    logic [6:0]  ctrl_q;
    logic [6:0]  ctrl_d;
    logic        flag_q;
    logic        flag_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    pmt8_phase_e phase_q;
    pmt8_phase_e phase_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic        run_enable;
    logic        tick;
    logic        match;
    logic        pre_pulse;
    logic        post_pulse;
    logic        wr_count;
    logic        wr_period;
    logic        wr_ctrl;
    logic        wr_flags;
    logic        scaler_clear;
    logic        take;

    assign run_enable = ctrl_q[`PMT8_RUN_BIT];
    // instruction clock enable: one pulse every four mclk
    assign tick  = run_enable && (iclk_q == `PMT8_ICLK_DIV); // [R01] [R12] [R16]
    assign match = (count_q == period_q);                    // [R05]

    // ahb slave: zero wait states, writes land in the data phase
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign wr_count  = (phase_q == PMT8_PHASE_WRITE) && (addr_q == `PMT8_ADDR_COUNT);
    assign wr_period = (phase_q == PMT8_PHASE_WRITE) && (addr_q == `PMT8_ADDR_PERIOD);
    assign wr_ctrl   = (phase_q == PMT8_PHASE_WRITE) && (addr_q == `PMT8_ADDR_CONTROL);
    assign wr_flags  = (phase_q == PMT8_PHASE_WRITE) && (addr_q == `PMT8_ADDR_FLAGS);
    assign scaler_clear = wr_count || wr_ctrl;               // [R14]
    assign match_interrupt_flag = flag_q;
    assign timer_count_out      = count_q;

    pmt8_scaler u_scaler (
        .mclk       (mclk),
        .reset      (reset),
        .clear      (scaler_clear),
        .tick_in    (tick),
        .pre_sel    (ctrl_q[`PMT8_CKPS_LSB +: 2]),              // [R13]
        .match_in   (match),
        .post_sel   (ctrl_q[`PMT8_OUTPS_LSB +: 4]),             // [R13]
        .pre_pulse  (pre_pulse),
        .post_pulse (post_pulse)
    );

    always_comb begin
        phase_d = PMT8_PHASE_IDLE;
        addr_d  = addr_q;
        if (take) begin
            addr_d  = {haddr[11:2], 2'b00};
            phase_d = hwrite ? PMT8_PHASE_WRITE : PMT8_PHASE_READ;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (take && !hwrite) begin
            case ({haddr[11:2], 2'b00})
                `PMT8_ADDR_COUNT:   rdata_d = {24'h0, count_q};   // [R10]
                `PMT8_ADDR_PERIOD:  rdata_d = {24'h0, period_q};  // [R10]
                `PMT8_ADDR_CONTROL: rdata_d = {25'h0, ctrl_q};
                `PMT8_ADDR_FLAGS:   rdata_d = {30'h0, flag_q, 1'b0};
                default:            rdata_d = 32'h0;
            endcase
        end
    end

    always_comb begin
        iclk_d   = iclk_q + 2'h1;
        count_d  = count_q;
        period_d = period_q;
        ctrl_d   = ctrl_q;
        flag_d   = flag_q;
        if (pre_pulse)
            count_d = match ? 8'h00 : count_q + 8'h01;       // [R04] [R06]
        if (wr_count)
            count_d = hwdata[7:0];                           // [R10]
        if (wr_period)
            period_d = hwdata[7:0];                          // [R10]
        if (wr_ctrl)
            ctrl_d = hwdata[6:0];                            // [R15]
        if (wr_flags && !hwdata[`PMT8_FLAG_BIT])
            flag_d = 1'b0;
        if (post_pulse)
            flag_d = 1'b1;                                   // [R09]
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            iclk_q   <= 2'h0;
            count_q  <= `PMT8_COUNT_RESET;                   // [R11]
            period_q <= `PMT8_PERIOD_RESET;                  // [R11]
            ctrl_q   <= `PMT8_CTRL_RESET;
            flag_q   <= 1'b0;
            rdata_q  <= 32'h0;
            phase_q  <= PMT8_PHASE_IDLE;
            addr_q   <= 12'h000;
        end else begin
            iclk_q   <= iclk_d;
            count_q  <= count_d;
            period_q <= period_d;
            ctrl_q   <= ctrl_d;
            flag_q   <= flag_d;
            rdata_q  <= rdata_d;
            phase_q  <= phase_d;
            addr_q   <= addr_d;
        end
    end

    stop_holds_a: assert property (@(posedge mclk) disable iff (reset) // [R16]
        !run_enable && !wr_count |=> $stable(count_q))
        else $error("counter moved while stopped");
    tick_rate_a: assert property (@(posedge mclk) disable iff (reset) // [R01]
        tick |=> !tick ##1 !tick ##1 !tick)
        else $error("tick faster than one in four");
    wrap_zero_a: assert property (@(posedge mclk) disable iff (reset) // [R06]
        pre_pulse && match && !wr_count |=> count_q == 8'h00)
        else $error("counter did not wrap at match");
    incr_a: assert property (@(posedge mclk) disable iff (reset) // [R04]
        pre_pulse && !match && !wr_count |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not increment");
    flag_set_a: assert property (@(posedge mclk) disable iff (reset) // [R09]
        post_pulse |=> flag_q)
        else $error("flag not set by postscaler");
    ctrl_keep_a: assert property (@(posedge mclk) disable iff (reset) // [R15]
        wr_ctrl && !pre_pulse |=> $stable(count_q))
        else $error("control write changed counter");
    reset_vals_a: assert property (@(posedge mclk) // [R11]
        reset |=> count_q == 8'h00 && period_q == 8'hff)
        else $error("reset values wrong");
    pre_div1_a: assert property (@(posedge mclk) disable iff (reset) // [R03]
        tick && ctrl_q[1:0] == 2'h0 && !scaler_clear |-> pre_pulse)
        else $error("prescale one missed a tick");
    no_idle_a: assert property (@(posedge mclk) disable iff (reset) // [R12]
        !run_enable |-> !pre_pulse && !post_pulse)
        else $error("prescaler output while stopped");
endmodule

/* dv/period_match_timer8_test.sv */
// Purpose: self-checking bench for the eight-bit period match timer
// Assumes: zero-wait AHB-Lite slave, hready tied to hreadyout
// Notes:   match intervals measured between flag rises, so tick phase does not matter
`timescale 1ns/100ps
`include "pmt8_defs.svh"
module period_match_timer8_test;
    logic        mclk, reset, hwrite, flag_prev, run_on, hreadyout, hresp, match_interrupt_flag;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd, v;
    logic [7:0]  timer_count_out, c;
    int          miscompares, check_count, cyc, chk_per, seed;
    int          rises[$];

    pmt8_timer dut (.mclk(mclk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .match_interrupt_flag(match_interrupt_flag),
        .timer_count_out(timer_count_out));

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge mclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_rises(input int n);
        int k;
        for (k = 0; k < 20000 && rises.size() < n; k++) @(posedge mclk);
    endtask

    // one match interval must equal 4 * prescale * (period + 1) * postscale clocks
    task automatic measure(input int pre, input int post, input int p);
        int iv;
        bus(`PMT8_ADDR_CONTROL, 1, 0);
        bus(`PMT8_ADDR_COUNT, 1, 0);
        bus(`PMT8_ADDR_PERIOD, 1, p);
        chk_per = p;
        bus(`PMT8_ADDR_CONTROL, 1, (post << 3) | 4 | pre);
        run_on = 1;
        bus(`PMT8_ADDR_FLAGS, 1, 0);
        rises.delete();
        wait_rises(1);
        bus(`PMT8_ADDR_FLAGS, 1, 0);
        wait_rises(2);
        iv = 4 * (pre == 0 ? 1 : pre == 1 ? 4 : 16) * (p + 1) * (post + 1);
        check(32'(rises.size() > 1 ? rises[1] - rises[0] : 0), 32'(iv));
        run_on = 0;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (match_interrupt_flag === 1'b1 && flag_prev !== 1'b1)
            rises.push_back(cyc);
        flag_prev = match_interrupt_flag;
        if (run_on)
            check(32'(timer_count_out <= chk_per), 1);
    end

    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        seed = 32'hcaa2;
        reset = 1;
        htrans = 0;
        haddr = 0;
        hwrite = 0;
        hwdata = 0;
        run_on = 0;
        repeat (16) @(posedge mclk);
        reset <= 0;
        bus(`PMT8_ADDR_COUNT, 0, 0);
        check(rd, `PMT8_COUNT_RESET);
        bus(`PMT8_ADDR_PERIOD, 0, 0);
        check(rd, `PMT8_PERIOD_RESET);
        bus(`PMT8_ADDR_CONTROL, 0, 0);
        check(rd, `PMT8_CTRL_RESET);
        check(32'(match_interrupt_flag), 0);
        check(32'(hresp), 0);
        $display("test reset done");
        repeat (4) begin
            v = $random(seed);
            bus(`PMT8_ADDR_COUNT, 1, v);
            bus(`PMT8_ADDR_PERIOD, 1, ~v);
            bus(`PMT8_ADDR_COUNT, 0, 0);
            check(rd, {24'h0, v[7:0]});
            bus(`PMT8_ADDR_PERIOD, 0, 0);
            check(rd, {24'h0, ~v[7:0]});
        end
        bus(12'h010, 1, 32'hffffffff);
        bus(12'h010, 0, 0);
        check(rd, 0);
        $display("test access done");
        bus(`PMT8_ADDR_CONTROL, 1, 32'h28);
        bus(`PMT8_ADDR_COUNT, 0, 0);
        check(rd, {24'h0, v[7:0]});
        repeat (40) @(posedge mclk);
        check({24'h0, timer_count_out}, {24'h0, v[7:0]});
        bus(`PMT8_ADDR_COUNT, 1, 0);
        bus(`PMT8_ADDR_PERIOD, 1, 32'hff);
        bus(`PMT8_ADDR_CONTROL, 1, 4);
        repeat (30) @(posedge mclk);
        bus(`PMT8_ADDR_CONTROL, 1, 0);
        repeat (2) @(posedge mclk);
        c = timer_count_out;
        check(32'(c != 0), 1);
        repeat (40) @(posedge mclk);
        check({24'h0, timer_count_out}, {24'h0, c});
        $display("test stop done");
        for (int pre = 0; pre < 4; pre++)
            for (int j = 0; j < 3; j++)
                measure(pre, j == 0 ? 0 : j == 1 ? 1 : 15, 1 + ($unsigned($random(seed)) % 3));
        $display("test period done");
        report_and_stop();
    end
endmodule
